// [hw/quasi_port_defs.svh]
/*
 * constants for the quasi-bidirectional port block: reset values,
 * widths, alternate-function bit positions and pull-up boost timing.
 * assumes inclusion by bare name from the block's design files.
 */
`ifndef QUASI_PORT_DEFS_SVH
`define QUASI_PORT_DEFS_SVH

// latch value after any reset: all ones, pins released
`define QB_LATCH_RESET 8'hff
// widths of ports 0..3 and of port 4
`define QB_PORT_WIDTH 8
`define QB_P4_WIDTH 5
// strong pull-up boost: oscillator periods, one period is one core_clk
`define QB_BOOST_OSC_PERIODS 2
`define QB_BOOST_CYCLES (`QB_BOOST_OSC_PERIODS * 1)
`define QB_BOOST_W 2
// port 3 alternate-function bit positions
`define QB_P3_IRQ0 2
`define QB_P3_IRQ1 3
`define QB_P3_TMR0 4
`define QB_P3_TMR1 5
`define QB_P3_MEM_WR 6
`define QB_P3_MEM_RD 7
// port 4 alternate-function bit positions
`define QB_P4_CAN_TX 0
`define QB_P4_CAN_RX 1
`define QB_P4_MISO 2
`define QB_P4_SCK 3
`define QB_P4_MOSI 4

`endif

// [hw/quasi_port_pkg.sv]
/*
 * types shared by the port block: port select and port byte.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package quasi_port_pkg;
  typedef logic [7:0] port_byte_t;
  typedef enum logic [2:0] {
    PORT_ZERO  = 3'h0,
    PORT_ONE   = 3'h1,
    PORT_TWO   = 3'h2,
    PORT_THREE = 3'h3,
    PORT_FOUR  = 3'h4
  } port_sel_t;
endpackage

`default_nettype wire

// [hw/port_slice.sv]
/*
 * one port: latch, pin sample, pull-up boost timers and pad drive.
 * assumes pins synchronous to core_clk and a caller that supplies
 * alternate outputs, bus override data and analog selects.
 */
`include "quasi_port_defs.svh"
`default_nettype none

module port_slice #(
  parameter int WIDTH   = `QB_PORT_WIDTH,
  parameter bit QUASI   = 1'b1,
  parameter bit WEAK_PU = 1'b1
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // cpu write
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // function select and override
  input  wire logic [7:0] alt_out,
  input  wire logic       bus_en,
  input  wire logic [7:0] bus_data,
  input  wire logic [7:0] analog_sel,
  // pad
  input  wire logic [7:0] pin_in,
  output logic      [7:0] latch_ff,
  output logic      [7:0] pin_ff,
  output logic      [7:0] pin_out_ff,
  output logic      [7:0] pin_oe_n_ff,
  output logic      [7:0] boost_ff,
  output logic      [7:0] weak_pu_ff
);
  localparam logic [7:0] IMPL = 8'((9'h1 << WIDTH) - 9'h1);

  generate
    if (WIDTH < 1 || WIDTH > `QB_PORT_WIDTH) begin : g_bad_width
      $error("port_slice: WIDTH must lie in 1..8");
    end
  endgenerate

  logic [7:0] nxt_latch_ff;
  logic [7:0] nxt_pin_ff;
  logic [7:0] nxt_weak_pu_ff;
  logic [7:0] nxt_pin_out_ff;
  logic [7:0] nxt_pin_oe_n_ff;
  logic [7:0] nxt_boost_ff;

  // latch load, pin sample; missing bits hold and read as one
  always_comb begin
    nxt_latch_ff   = wr_en ? (wr_data | ~IMPL) : latch_ff;
    nxt_pin_ff     = pin_in | ~IMPL;
    nxt_weak_pu_ff = WEAK_PU ? ~analog_sel : 8'h00;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_ff    <= `QB_LATCH_RESET;
      pin_ff      <= 8'hff;
      weak_pu_ff  <= 8'h00;
      pin_out_ff  <= 8'hff;
      pin_oe_n_ff <= 8'hff;
      boost_ff    <= 8'h00;
    end else begin
      latch_ff    <= nxt_latch_ff;
      pin_ff      <= nxt_pin_ff;
      weak_pu_ff  <= nxt_weak_pu_ff;
      pin_out_ff  <= nxt_pin_out_ff;
      pin_oe_n_ff <= nxt_pin_oe_n_ff;
      boost_ff    <= nxt_boost_ff;
    end
  end

  // per-bit drive and boost timer; pad follows the latch a cycle later
  for (genvar b = 0; b < 8; b++) begin : g_bit
    logic [`QB_BOOST_W-1:0] cnt_ff;
    logic [`QB_BOOST_W-1:0] nxt_cnt_ff;
    logic                   src;
    logic                   nxt_out;
    logic                   nxt_oe_n;
    logic                   nxt_boost;

    always_comb begin
      src        = bus_en ? bus_data[b] : (latch_ff[b] & alt_out[b]);
      nxt_cnt_ff = (cnt_ff != '0) ? cnt_ff - `QB_BOOST_W'(1) : '0;
      if (QUASI && nxt_latch_ff[b] && !latch_ff[b]) begin
        nxt_cnt_ff = `QB_BOOST_W'(`QB_BOOST_CYCLES);
      end
      nxt_boost = (QUASI && cnt_ff != '0) || (bus_en && src);
      if (bus_en) begin
        nxt_oe_n = 1'b0;
        nxt_out  = src;
      end else if (!src) begin
        nxt_oe_n = 1'b0;
        nxt_out  = 1'b0;
      end else if (nxt_boost) begin
        nxt_oe_n = 1'b0;
        nxt_out  = 1'b1;
      end else begin
        nxt_oe_n = 1'b1;
        nxt_out  = 1'b1;
      end
    end

    // boost timer of this bit; pad registers sit in the shared process
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= nxt_cnt_ff;
      end
    end

    // hand this bit's next pad drive to the shared registers
    assign nxt_pin_out_ff[b]  = nxt_out;
    assign nxt_pin_oe_n_ff[b] = nxt_oe_n;
    assign nxt_boost_ff[b]    = nxt_boost;
  end

endmodule

`default_nettype wire

// [hw/quasi_bidir_port_mux.sv]
/*
 * five parallel ports of an 8-bit controller: latches, latch and pin
 * read paths, alternate-function muxing and external-bus override of
 * ports 0 and 2. assumes pins synchronous to core_clk, one cpu access
 * per cycle and a bus sequencer that drives the bus_* and mem_* inputs.
 */
// Notes on behaviour
// - cpu port write loads the port latch
// - separate latch read and pin read paths
// - read-modify-write reads latch, others read pin
// - each bit independently input or output
// - latch one switches off low-side driver
// - alternate function needs latch one, alt drives
// - port 3 alternate functions on bits 2..7
// - port 4 five bits: can and spi
// - write strobe captures port 0 data byte
// - bus cycle switches driver to address/data
// - bus port not available for plain io
// - port 0 open-drain except bus cycles
// - port 2 strong pull-up during bus address
// - port 1 analog select drops pull-up
// - reset sets every latch bit to one
// - zero-to-one latch change boosts two periods
// - latch updates, pin follows next cycle
`include "quasi_port_defs.svh"
`default_nettype none

module quasi_bidir_port_mux
  import quasi_port_pkg::*;
#(
  parameter int P4_WIDTH = `QB_P4_WIDTH
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // cpu write
  input  wire logic            wr_en,
  input  wire port_sel_t       wr_sel,
  input  wire port_byte_t      wr_data,
  // cpu read
  input  wire logic            rd_en,
  input  wire port_sel_t       rd_sel,
  input  wire logic            rd_rmw,
  output port_byte_t           rd_data_ff,
  output logic                 rd_valid_ff,
  // peripheral alternate outputs
  input  wire logic [7:0]      alt_out_p1,
  input  wire logic [7:0]      alt_out_p3,
  input  wire logic            can_transmit_out,
  input  wire logic [2:0]      spi_alt_out,
  input  wire logic [7:0]      analog_sel_p1,
  // external memory bus
  input  wire logic            bus_active_p0,
  input  wire port_byte_t      bus_data_p0,
  input  wire logic            bus_active_p2,
  input  wire port_byte_t      bus_addr_p2,
  input  wire logic            mem_wr_n,
  input  wire logic            mem_rd_n,
  // peripheral alternate inputs
  output logic                 ext_irq_zero_input_ff,
  output logic                 ext_irq_one_input_ff,
  output logic                 timer_zero_count_in_ff,
  output logic                 timer_one_count_in_ff,
  output logic                 spi_ss_in_ff,
  output logic                 can_receive_in_ff,
  output logic [2:0]           spi_alt_in_ff,
  // pads
  input  wire logic [4:0][7:0] pin_in,
  output wire logic [4:0][7:0] pin_out_ff,
  output wire logic [4:0][7:0] pin_oe_n_ff,
  output wire logic [4:0][7:0] pull_boost_ff,
  output wire logic [4:0][7:0] weak_pull_en_ff
);
  localparam logic [7:0] P4_MASK = 8'((9'h1 << P4_WIDTH) - 9'h1);

  generate
    if (P4_WIDTH != `QB_P4_WIDTH) begin : g_bad_p4
      $error("quasi_bidir_port_mux: port 4 alternate map needs five bits");
    end
  endgenerate

  logic [4:0][7:0] latch_all;
  logic [4:0][7:0] pin_all;
  logic [4:0][7:0] alt_v;
  logic [4:0][7:0] bus_v;
  logic [4:0]      bus_en_v;
  logic [4:0]      wr_v;

  // per-port selects, alternate outputs and bus override
  always_comb begin
    wr_v     = '0;
    if (wr_en && wr_sel <= PORT_FOUR) begin
      wr_v[wr_sel] = 1'b1;
    end
    alt_v    = {5{8'hff}};
    alt_v[1] = alt_out_p1;
    alt_v[3] = {mem_rd_n, mem_wr_n, alt_out_p3[5:0]};
    alt_v[4] = {3'h7, spi_alt_out, 1'b1, can_transmit_out};
    bus_v    = {5{8'hff}};
    bus_v[0] = bus_data_p0;
    bus_v[2] = bus_addr_p2;
    bus_en_v = {2'h0, bus_active_p2, 1'b0, bus_active_p0};
  end

  // one slice per port; port 0 open-drain, port 4 five bits
  for (genvar p = 0; p < 5; p++) begin : g_port
    port_slice #(
      .WIDTH   ((p == 4) ? P4_WIDTH : `QB_PORT_WIDTH),
      .QUASI   (p != 0),
      .WEAK_PU (p != 0)
    ) u_port (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .wr_en       (wr_v[p]),
      .wr_data     (wr_data),
      .alt_out     (alt_v[p]),
      .bus_en      (bus_en_v[p]),
      .bus_data    (bus_v[p]),
      .analog_sel  ((p == 1) ? analog_sel_p1 : 8'h00),
      .pin_in      (pin_in[p]),
      .latch_ff    (latch_all[p]),
      .pin_ff      (pin_all[p]),
      .pin_out_ff  (pin_out_ff[p]),
      .pin_oe_n_ff (pin_oe_n_ff[p]),
      .boost_ff    (pull_boost_ff[p]),
      .weak_pu_ff  (weak_pull_en_ff[p])
    );
  end

  port_byte_t nxt_rd_data_ff;
  logic       nxt_rd_valid_ff;

  // read mux: rmw reads latch, other reads sample pin
  always_comb begin
    nxt_rd_data_ff  = rd_data_ff;
    nxt_rd_valid_ff = rd_en;
    if (rd_en) begin
      if (rd_sel > PORT_FOUR) begin
        nxt_rd_data_ff = 8'hff;
      end else if (rd_rmw) begin
        nxt_rd_data_ff = latch_all[rd_sel];
      end else begin
        nxt_rd_data_ff = pin_all[rd_sel];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff  <= 8'hff;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data_ff;
      rd_valid_ff <= nxt_rd_valid_ff;
    end
  end

  logic       nxt_irq0;
  logic       nxt_irq1;
  logic       nxt_tmr0;
  logic       nxt_tmr1;
  logic       nxt_can_rx;
  logic [2:0] nxt_spi_in;

  // alternate inputs from pin samples
  always_comb begin
    nxt_irq0   = pin_all[3][`QB_P3_IRQ0];
    nxt_irq1   = pin_all[3][`QB_P3_IRQ1];
    nxt_tmr0   = pin_all[3][`QB_P3_TMR0];
    nxt_tmr1   = pin_all[3][`QB_P3_TMR1];
    nxt_can_rx = pin_all[4][`QB_P4_CAN_RX];
    nxt_spi_in = pin_all[4][`QB_P4_MOSI:`QB_P4_MISO];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_irq_zero_input_ff  <= 1'b1;
      ext_irq_one_input_ff   <= 1'b1;
      timer_zero_count_in_ff <= 1'b1;
      timer_one_count_in_ff  <= 1'b1;
      spi_ss_in_ff           <= 1'b1;
      can_receive_in_ff      <= 1'b1;
      spi_alt_in_ff          <= 3'h7;
    end else begin
      ext_irq_zero_input_ff  <= nxt_irq0;
      ext_irq_one_input_ff   <= nxt_irq1;
      timer_zero_count_in_ff <= nxt_tmr0;
      timer_one_count_in_ff  <= nxt_tmr1;
      spi_ss_in_ff           <= nxt_tmr1;
      can_receive_in_ff      <= nxt_can_rx;
      spi_alt_in_ff          <= nxt_spi_in;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_latch_load: assert property (
    wr_en && wr_sel == PORT_TWO |=> latch_all[2] == $past(wr_data))
    else $error("port 2 latch did not load the written byte");
  a_read_latch: assert property (
    rd_en && rd_rmw && rd_sel == PORT_THREE |=> rd_data_ff == $past(latch_all[3]))
    else $error("rmw read did not return the latch");
  a_read_pin: assert property (
    rd_en && !rd_rmw && rd_sel == PORT_ONE |=> rd_valid_ff && rd_data_ff == $past(pin_all[1]))
    else $error("plain read did not return the pin sample");
  a_drive_low: assert property (
    !latch_all[1][0] |=> !pin_oe_n_ff[1][0] && !pin_out_ff[1][0])
    else $error("cleared latch bit not driven low");
  a_input_release: assert property (
    (latch_all[1][0] && alt_out_p1[0]) [*4] |=> pin_oe_n_ff[1][0])
    else $error("set latch bit still drives the pin");
  a_alt_drive: assert property (
    latch_all[3][0] && !alt_out_p3[0] |=> !pin_out_ff[3][0] && !pin_oe_n_ff[3][0])
    else $error("alternate output low not driven");
  a_boost_on: assert property (
    $rose(latch_all[2][0]) |=> pull_boost_ff[2][0] [*2])
    else $error("boost not on for two cycles");
  a_boost_off: assert property (
    $rose(latch_all[2][0]) ##1 latch_all[2][0] [*2] |-> ##1 !pull_boost_ff[2][0])
    else $error("boost lasted past two cycles");
  a_p0_open_drain: assert property (
    !bus_active_p0 |=> (pin_out_ff[0] & ~pin_oe_n_ff[0]) == 8'h00 && pull_boost_ff[0] == 8'h00)
    else $error("port 0 drove a one outside a bus cycle");
  a_bus_override: assert property (
    bus_active_p2 |=> pin_out_ff[2] == $past(bus_addr_p2) && pin_oe_n_ff[2] == 8'h00)
    else $error("port 2 did not carry the bus address");
  a_wr_strobe: assert property (
    bus_active_p0 && !mem_wr_n && latch_all[3][6]
      |=> !pin_out_ff[3][6] && pin_out_ff[0] == $past(bus_data_p0))
    else $error("write strobe not presented with port 0 data");
  a_p4_upper: assert property (
    rd_en && rd_sel == PORT_FOUR |=> (rd_data_ff | P4_MASK) == 8'hff)
    else $error("port 4 unused bits did not read as one");

  c_boost: cover property ($rose(latch_all[2][7]) ##1 pull_boost_ff[2][7]);
  c_wr_cycle: cover property (bus_active_p0 && !mem_wr_n);
  c_rmw_read: cover property (rd_en && rd_rmw ##1 rd_valid_ff);
  c_pin_diff: cover property (rd_en && !rd_rmw && latch_all[1] != pin_all[1]);

endmodule

`default_nettype wire

// [dv/pad_model.sv]
/*
 * pad model: resolves the level on every pin of the five ports.
 * assumes the block's pad outputs settle after core_clk rising edges.
 */
`default_nettype none

module pad_model (
  // clock
  input  wire logic            core_clk,
  // block drive
  input  wire logic [4:0][7:0] pin_out_ff,
  input  wire logic [4:0][7:0] pin_oe_n_ff,
  input  wire logic [4:0][7:0] weak_pull_en_ff,
  // outside drivers
  input  wire logic [4:0][7:0] ext_en,
  input  wire logic [4:0][7:0] ext_val,
  // level seen by the block
  output logic      [4:0][7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0][7:0] last_ff = '0;
  // a floating line shows the inverse of its last level
  always_ff @(posedge core_clk) begin
    last_ff <= pin_in;
  end
  // block driver, then outside driver, then pull-up, else floating
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!pin_oe_n_ff[p][b]) pin_in[p][b] = pin_out_ff[p][b];
        else if (ext_en[p][b]) pin_in[p][b] = ext_val[p][b];
        else if (weak_pull_en_ff[p][b]) pin_in[p][b] = 1'b1;
        else pin_in[p][b] = ~last_ff[p][b];
      end
    end
  end
endmodule

`default_nettype wire

// [dv/quasi_bidir_port_mux_bench.sv]
/*
 * bench for the port block: scenario tasks and closing report.
 * assumes the pad model and the design files are compiled first.
 */
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, exp, got); end end

module quasi_bidir_port_mux_bench
  import quasi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, rd_rmw = 0;
  logic can_tx = 1, bus0 = 0, bus2 = 0, mem_wr_n = 1, mem_rd_n = 1;
  port_sel_t wr_sel = PORT_ZERO, rd_sel = PORT_ZERO;
  port_byte_t wr_data = '0, bus_data = '0, bus_addr = '0, rd_data;
  logic [7:0] alt1 = '1, alt3 = '1, ana = '0;
  logic [2:0] spi_out = '1, spi_in;
  logic rd_valid, irq0, irq1, tm0, tm1, ss, canrx;
  logic [4:0][7:0] ext_en = '0, ext_val = '0;
  wire logic [4:0][7:0] pin_in, pout, poe, pboost, pweak;
  int miscompares = 0, n_tests = 0, cyc = 0;

  // clock and cycle ceiling
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  quasi_bidir_port_mux dut (.core_clk(core_clk), .reset_n(reset_n), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_sel(rd_sel), .rd_rmw(rd_rmw),
    .rd_data_ff(rd_data), .rd_valid_ff(rd_valid), .alt_out_p1(alt1), .alt_out_p3(alt3),
    .can_transmit_out(can_tx), .spi_alt_out(spi_out), .analog_sel_p1(ana),
    .bus_active_p0(bus0), .bus_data_p0(bus_data), .bus_active_p2(bus2),
    .bus_addr_p2(bus_addr), .mem_wr_n(mem_wr_n), .mem_rd_n(mem_rd_n),
    .ext_irq_zero_input_ff(irq0), .ext_irq_one_input_ff(irq1),
    .timer_zero_count_in_ff(tm0), .timer_one_count_in_ff(tm1), .spi_ss_in_ff(ss),
    .can_receive_in_ff(canrx), .spi_alt_in_ff(spi_in), .pin_in(pin_in),
    .pin_out_ff(pout), .pin_oe_n_ff(poe), .pull_boost_ff(pboost), .weak_pull_en_ff(pweak));

  pad_model pads (.core_clk(core_clk), .pin_out_ff(pout), .pin_oe_n_ff(poe),
    .weak_pull_en_ff(pweak), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // one cpu write; returns in the time step of the taking edge
  task automatic wr(input port_sel_t s, input port_byte_t d);
    @(posedge core_clk);
    wr_en <= 1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 0;
  endtask

  // one cpu read, judged 1 ns after the taking edge
  task automatic rd(input port_sel_t s, input logic m, input port_byte_t exp);
    @(posedge core_clk);
    rd_en <= 1;
    rd_sel <= s;
    rd_rmw <= m;
    @(posedge core_clk);
    rd_en <= 0;
    #1;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", exp, rd_data)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset;
    for (int p = 0; p < 5; p++) rd(port_sel_t'(p), 1'b1, 8'hff);
    rd(port_sel_t'(3'h5), 1'b0, 8'hff);
    `CHK("oe p1", 8'hff, poe[1])
    `CHK("weak p0", 8'h00, pweak[0])
  endtask

  // outside pulls a released bit low: latch and pin reads differ
  task automatic t_rmw;
    @(posedge core_clk);
    ext_en[1] <= 8'h02;
    wr(PORT_ONE, 8'h5a);
    settle(4);
    `CHK("oe p1", 8'h5a, poe[1])
    rd(PORT_ONE, 1'b1, 8'h5a);
    rd(PORT_ONE, 1'b0, 8'h58);
    ext_en[1] <= 8'h00;
  endtask

  task automatic t_boost;
    wr(PORT_TWO, 8'h00);
    #1;
    `CHK("oe p2 old", 8'hff, poe[2])
    settle(1);
    `CHK("oe p2 new", 8'h00, poe[2])
    wr(PORT_TWO, 8'h81);
    settle(1);
    `CHK("boost 1", 8'h81, pboost[2])
    settle(1);
    `CHK("boost 2", 8'h81, pboost[2])
    settle(1);
    `CHK("boost 3", 8'h00, pboost[2])
  endtask

  task automatic t_alt;
    @(posedge core_clk);
    alt3 <= 8'hfe;
    mem_wr_n <= 0;
    can_tx <= 0;
    spi_out <= 3'b110;
    ext_en[3] <= 8'h24;
    ext_en[4] <= 8'h0a;
    wr(PORT_FOUR, 8'hff);
    settle(3);
    `CHK("oe p3", 8'hbe, poe[3])
    `CHK("wr strobe", 1'b0, pout[3][6])
    `CHK("oe p4", 5'h1a, poe[4][4:0])
    `CHK("p3 inputs", 5'b01100, {irq0, irq1, tm0, tm1, ss})
    `CHK("can rx", 1'b0, canrx)
    `CHK("spi in", 3'b100, spi_in)
    @(posedge core_clk);
    alt3 <= 8'hff;
    mem_wr_n <= 1;
    can_tx <= 1;
    spi_out <= 3'b111;
    ext_en <= '0;
  endtask

  task automatic t_bus;
    wr(PORT_ZERO, 8'h0f);
    bus0 <= 1;
    bus2 <= 1;
    mem_wr_n <= 0;
    bus_data <= 8'h3c;
    bus_addr <= 8'ha5;
    settle(2);
    `CHK("oe p0 bus", 8'h00, poe[0])
    `CHK("out p0 bus", 8'h3c, pout[0])
    `CHK("boost p0 bus", 8'h3c, pboost[0])
    `CHK("out p2 bus", 8'ha5, pout[2])
    `CHK("boost p2 bus", 8'ha5, pboost[2])
    `CHK("wr strobe bus", 1'b0, pout[3][6])
    @(posedge core_clk);
    bus0 <= 0;
    bus2 <= 0;
    mem_wr_n <= 1;
    settle(2);
    `CHK("oe p0 io", 8'h0f, poe[0])
    `CHK("boost p0 io", 8'h00, pboost[0])
    `CHK("high p0 io", 8'h00, pout[0] & ~poe[0])
  endtask

  task automatic t_analog;
    @(posedge core_clk);
    ana <= 8'h81;
    settle(2);
    `CHK("weak p1", 8'h7e, pweak[1])
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    t_reset();
    t_rmw();
    t_boost();
    t_alt();
    t_bus();
    t_analog();
    close_out();
  end
endmodule

`default_nettype wire
